/* common/spa_pkg.sv */
// Purpose: Shared constants for the port 0 media-independent signal adapter.
// Assumes: One 20 MHz system clock; all register offsets are byte addresses.
// Notes: Register offsets and field positions are local choices for this block.
package spa_pkg;

  // ----------------------------------------------------------------
  // Interface modes, one-hot.
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SPA_MII_MAC = 4'h1,
    SPA_MII_PHY = 4'h2,
    SPA_RMII_MAC = 4'h4,
    SPA_RMII_PHY = 4'h8
  } spa_mode_type;

  // Strap encoding of the two mode straps.
  localparam logic [1:0] SPA_STRAP_MII_MAC = 2'h0;
  localparam logic [1:0] SPA_STRAP_MII_PHY = 2'h1;
  localparam logic [1:0] SPA_STRAP_RMII_MAC = 2'h2;
  localparam logic [1:0] SPA_STRAP_RMII_PHY = 2'h3;

  // ----------------------------------------------------------------
  // Register map.
  // ----------------------------------------------------------------
  localparam logic [7:0] SPA_BASIC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] SPA_SPECIAL_CTRL_ADDR = 8'h04;
  localparam logic [7:0] SPA_STATUS_ADDR = 8'h08;
  localparam logic [7:0] SPA_DATA_ADDR = 8'h0C;

  // Basic control fields.
  localparam int SPA_DUPLEX_BIT = 8;
  localparam int SPA_ISOLATE_BIT = 10;
  localparam int SPA_AUTONEG_BIT = 12;
  localparam int SPA_SPEED_LSB_BIT = 13;
  localparam logic [15:0] SPA_BASIC_RESET = 16'h1000;

  // Special control fields.
  localparam int SPA_CLKDIR_BIT = 0;
  localparam logic [15:0] SPA_SPECIAL_RESET = 16'h0000;

  // Data register fields: data[3:0], valid 8, error 9.
  localparam int SPA_VALID_BIT = 8;
  localparam int SPA_ERROR_BIT = 9;

  // Status fields.
  localparam int SPA_STAT_SPEED_BIT = 0;
  localparam int SPA_STAT_DUPLEX_BIT = 1;
  localparam int SPA_STAT_MODE_LSB = 4;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int SPA_CLK_MHZ = 20;
  localparam int SPA_SYNC_STAGES = 2;

endpackage

/* core/spa_port_adapter.sv */
// Purpose: Port 0 MII/RMII signal adapter with an AHB-Lite register slave.
// Assumes: Link clocks are sampled by clk; straps are stable at reset release.
// Notes: Output data changes on a detected edge of the active link clock.
//
// Function
// - In MII MAC mode the valid output is transmit enable over four data bits.
// - In MII PHY mode the valid output is receive data valid toward the MAC.
// - In PHY-side modes isolate disables every output toward the MAC.
// - In RMII MAC mode the valid output is transmit enable over two data bits.
// - In RMII PHY mode the valid output is carrier sense and data valid.
// - In MII MAC mode the error output carries transmit error for low power idle.
// - In RMII MAC mode the speed input is sampled continuously as a live value.
// - With autonegotiation off the speed select bit replaces the speed input.
// - The speed polarity strap sets the active level of the speed input.
// - In MAC modes the duplex input is sampled continuously as a live value.
// - With autonegotiation off the duplex mode bit replaces the duplex input.
// - The duplex polarity strap sets the active level of the duplex input.
// - In PHY modes the speed and duplex inputs are ignored.
// - In MII MAC mode the partner clock times data, valid and error.
// - In MII PHY mode the device generates the output clock toward the MAC.
// - In RMII modes a reference clock, from the partner or the 10 MHz device clock per the direction bit, times data.
`timescale 1ns/1ps
module spa_port_adapter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] modeStrap,
  input wire logic speedPolStrap,
  input wire logic duplexPolStrap,
  input wire logic portSpeedIn,
  input wire logic portDuplexIn,
  input wire logic portOutClockIn,
  input wire logic portRmiiRefClockIn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [3:0] portOutData,
  output logic [3:0] portOutDataOe,
  output logic portOutDataValid,
  output logic portOutDataValidOe,
  output logic portOutError,
  output logic portOutErrorOe,
  output logic portOutClockOut,
  output logic portOutClockOe,
  output logic portRmiiRefClockOut,
  output logic portRmiiRefClockOe,
  output logic linkSpeed,
  output logic linkFullDuplex
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic strapDone;
    spa_pkg::spa_mode_type mode;
    logic speedPol;
    logic duplexPol;
    logic [15:0] basicCtrl;
    logic [15:0] specialCtrl;
    logic [9:0] txWord;
    logic wrPending;
    logic [7:0] wrAddr;
    logic rdPending;
    logic [31:0] rdata;
    logic clkPrev;
    logic clkDiv;
    logic [3:0] outData;
    logic [3:0] outDataOe;
    logic outValid;
    logic outValidOe;
    logic outError;
    logic outErrorOe;
    logic outClock;
    logic outClockOe;
    logic refClock;
    logic refClockOe;
    logic speed;
    logic duplex;
  } spa_core_state_type;

  spa_core_state_type state;
  spa_core_state_type next_state;
  logic speedSync;
  logic duplexSync;
  logic outClkSync;
  logic refClkSync;

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  // Live inputs and incoming clocks each pass two flops before use.
  spa_sync syncSpeed (.clk(clk), .rst_n(rst_n), .asyncIn(portSpeedIn), .syncOut(speedSync));
  spa_sync syncDuplex (.clk(clk), .rst_n(rst_n), .asyncIn(portDuplexIn), .syncOut(duplexSync));
  spa_sync syncOutClk (.clk(clk), .rst_n(rst_n), .asyncIn(portOutClockIn), .syncOut(outClkSync));
  spa_sync syncRefClk (.clk(clk), .rst_n(rst_n), .asyncIn(portRmiiRefClockIn),
    .syncOut(refClkSync));

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  logic isMac;
  logic isPhy;
  logic isRmii;
  logic isolate;
  logic autoneg;
  logic refFromDevice;
  logic linkClk;
  logic linkEdge;
  logic addrPhase;
  logic [3:0] dataMask;

  // Mode decode and link clock selection.
  always_comb
  begin
    isMac = (state.mode == spa_pkg::SPA_MII_MAC) || (state.mode == spa_pkg::SPA_RMII_MAC);
    isPhy = !isMac;
    isRmii = (state.mode == spa_pkg::SPA_RMII_MAC) || (state.mode == spa_pkg::SPA_RMII_PHY);
    isolate = state.basicCtrl[spa_pkg::SPA_ISOLATE_BIT];
    autoneg = state.basicCtrl[spa_pkg::SPA_AUTONEG_BIT];
    refFromDevice = state.specialCtrl[spa_pkg::SPA_CLKDIR_BIT];
    linkClk = outClkSync;
    if (state.mode == spa_pkg::SPA_MII_PHY)
    begin
      linkClk = state.clkDiv;
    end
    else if (isRmii)
    begin
      linkClk = refFromDevice ? state.clkDiv : refClkSync;
    end
    linkEdge = linkClk && !state.clkPrev;
    addrPhase = hsel && hready && htrans[1];
    dataMask = isRmii ? 4'h3 : 4'hF;
  end

  always_comb
  begin
    next_state = state;
    if (!state.strapDone)
    begin
      next_state.strapDone = 1'b1;
      next_state.speedPol = speedPolStrap;
      next_state.duplexPol = duplexPolStrap;
      unique case (modeStrap)
        spa_pkg::SPA_STRAP_MII_MAC: next_state.mode = spa_pkg::SPA_MII_MAC;
        spa_pkg::SPA_STRAP_MII_PHY: next_state.mode = spa_pkg::SPA_MII_PHY;
        spa_pkg::SPA_STRAP_RMII_MAC: next_state.mode = spa_pkg::SPA_RMII_MAC;
        spa_pkg::SPA_STRAP_RMII_PHY: next_state.mode = spa_pkg::SPA_RMII_PHY;
      endcase
    end

    // Bus slave: address phase captured, write data applied in the data phase.
    next_state.wrPending = 1'b0;
    next_state.rdPending = 1'b0;
    if (state.wrPending)
    begin
      unique case (state.wrAddr)
        spa_pkg::SPA_BASIC_CTRL_ADDR: next_state.basicCtrl = hwdata[15:0];
        spa_pkg::SPA_SPECIAL_CTRL_ADDR: next_state.specialCtrl = hwdata[15:0];
        spa_pkg::SPA_DATA_ADDR: next_state.txWord = hwdata[9:0];
        default: next_state.basicCtrl = state.basicCtrl;
      endcase
    end
    if (addrPhase)
    begin
      next_state.wrPending = hwrite;
      next_state.rdPending = !hwrite;
      next_state.wrAddr = haddr[7:0];
      next_state.rdata = '0;
      unique case (haddr[7:0])
        spa_pkg::SPA_BASIC_CTRL_ADDR: next_state.rdata = {16'h0000, state.basicCtrl};
        spa_pkg::SPA_SPECIAL_CTRL_ADDR: next_state.rdata = {16'h0000, state.specialCtrl};
        spa_pkg::SPA_STATUS_ADDR:
          next_state.rdata = {24'h000000, state.mode, 2'h0, state.duplex, state.speed};
        spa_pkg::SPA_DATA_ADDR: next_state.rdata = {22'h000000, state.txWord};
        default: next_state.rdata = '0;
      endcase
    end

    // Device-made clock: toggles every cycle, 10 MHz from 20 MHz.
    next_state.clkDiv = !state.clkDiv;
    next_state.clkPrev = linkClk;

    next_state.speed = speedSync ^ state.speedPol;
    if (!state.speedPol)
    begin
      next_state.speed = speedSync;
    end
    if (!autoneg)
    begin
      next_state.speed = state.basicCtrl[spa_pkg::SPA_SPEED_LSB_BIT];
    end
    next_state.duplex = duplexSync ^ state.duplexPol;
    if (!autoneg)
    begin
      next_state.duplex = state.basicCtrl[spa_pkg::SPA_DUPLEX_BIT];
    end
    if (isPhy)
    begin
      next_state.speed = state.basicCtrl[spa_pkg::SPA_SPEED_LSB_BIT];
      next_state.duplex = state.basicCtrl[spa_pkg::SPA_DUPLEX_BIT];
    end

    if (linkEdge && state.strapDone)
    begin
      next_state.outData = state.txWord[3:0] & dataMask;
      next_state.outValid = state.txWord[spa_pkg::SPA_VALID_BIT];
      next_state.outError = (state.mode == spa_pkg::SPA_MII_MAC) &&
        state.txWord[spa_pkg::SPA_ERROR_BIT];
    end

    next_state.outDataOe = (isPhy && isolate) ? 4'h0 : dataMask;
    next_state.outValidOe = !(isPhy && isolate);
    next_state.outErrorOe = (state.mode == spa_pkg::SPA_MII_MAC);
    next_state.outClockOe = (state.mode == spa_pkg::SPA_MII_PHY) && !isolate;
    next_state.outClock = state.clkDiv;
    next_state.refClockOe = isRmii && refFromDevice && !(isPhy && isolate);
    next_state.refClock = state.clkDiv;
    if (!state.strapDone)
    begin
      next_state.outDataOe = 4'h0;
      next_state.outValidOe = 1'b0;
      next_state.outErrorOe = 1'b0;
      next_state.outClockOe = 1'b0;
      next_state.refClockOe = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  // Reset takes constants only; straps are caught on the first edge after release.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= '0;
      state.mode <= spa_pkg::SPA_MII_MAC;
      state.basicCtrl <= spa_pkg::SPA_BASIC_RESET;
      state.specialCtrl <= spa_pkg::SPA_SPECIAL_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from flops; hreadyout and hresp are tied constants.
  assign hrdata = state.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign portOutData = state.outData;
  assign portOutDataOe = state.outDataOe;
  assign portOutDataValid = state.outValid;
  assign portOutDataValidOe = state.outValidOe;
  assign portOutError = state.outError;
  assign portOutErrorOe = state.outErrorOe;
  assign portOutClockOut = state.outClock;
  assign portOutClockOe = state.outClockOe;
  assign portRmiiRefClockOut = state.refClock;
  assign portRmiiRefClockOe = state.refClockOe;
  assign linkSpeed = state.speed;
  assign linkFullDuplex = state.duplex;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_MODE_FIXED: assert property (state.strapDone |=> $stable(state.mode))
    else $error("Mode changed after latch.");
  AST_ISOLATE_OFF: assert property (state.strapDone && isPhy && isolate |=>
    !portOutDataValidOe && portOutDataOe == 4'h0)
    else $error("Outputs driven while isolated.");
  AST_CLK_OE_ISO: assert property (isolate |=> !portOutClockOe)
    else $error("Clock driven while isolated.");
  AST_PHY_CLK_OUT: assert property (state.strapDone && state.mode == spa_pkg::SPA_MII_PHY
    && !isolate |=> portOutClockOe)
    else $error("Phy mode clock not driven.");
  AST_ERR_ONLY_MII_MAC: assert property (state.mode != spa_pkg::SPA_MII_MAC |=>
    !portOutErrorOe ##0 !portOutError)
    else $error("Error pin used outside mii mac.");
  AST_VALID_ON_EDGE: assert property (state.strapDone && !linkEdge |=>
    $stable(portOutDataValid))
    else $error("Valid changed off link edge.");
  AST_VALID_FOLLOWS: assert property (state.strapDone && linkEdge |=>
    portOutDataValid == $past(state.txWord[spa_pkg::SPA_VALID_BIT]))
    else $error("Valid does not follow word.");
  AST_RMII_TWO_BITS: assert property (isRmii |=> portOutData[3:2] == 2'h0)
    else $error("Rmii upper data bits active.");
  AST_RMII_REF_OE: assert property (isRmii && !refFromDevice |=> !portRmiiRefClockOe)
    else $error("Reference driven as input.");
  AST_SPEED_OVR: assert property (!autoneg ##1 !autoneg |->
    linkSpeed == $past(state.basicCtrl[spa_pkg::SPA_SPEED_LSB_BIT]))
    else $error("Speed override ignored.");
  AST_DUPLEX_OVR: assert property (!autoneg ##1 !autoneg |->
    linkFullDuplex == $past(state.basicCtrl[spa_pkg::SPA_DUPLEX_BIT]))
    else $error("Duplex override ignored.");
  // The polarity flop is still at reset in the strap cycle, so that cycle is left out.
  AST_DUPLEX_LIVE: assert property (state.strapDone && isMac && autoneg |=>
    linkFullDuplex == ($past(duplexSync) ^ state.duplexPol))
    else $error("Duplex not live.");
  AST_SPEED_POL: assert property (state.strapDone && isMac && autoneg |=>
    linkSpeed == ($past(speedSync) ^ state.speedPol))
    else $error("Speed polarity wrong.");

  COV_ISOLATE: cover property (isPhy && isolate);
  COV_RMII_TX: cover property (isRmii && linkEdge && state.txWord[spa_pkg::SPA_VALID_BIT]);
  COV_OVERRIDE: cover property (!autoneg && isMac);

endmodule

/* core/spa_sync.sv */
// Purpose: Two-flop synchroniser for one bit from outside the clock domain.
// Assumes: Input is a level; only the second stage is read.
// Notes: Reset value is a constant zero.
`timescale 1ns/1ps
module spa_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic asyncIn,
  output logic syncOut
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } spa_sync_state_type;

  spa_sync_state_type state;
  spa_sync_state_type next_state;

  // The first stage feeds only the second.
  always_comb
  begin
    next_state.stage1 = asyncIn;
    next_state.stage2 = state.stage1;
  end

  // Both stages clear asynchronously.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign syncOut = state.stage2;

endmodule

/* testbench/spa_link_partner.sv */
// Purpose: Behavioural model of the external PHY or MAC on port 0.
// Assumes: Its link clock runs only while the bench asks for a frame.
// Notes: Speed and duplex pins are plain levels set by the bench.
`timescale 1ns/1ps
module spa_link_partner #(
  parameter int HALF_NS = 200
) (
  input wire logic clkRun,
  input wire logic speedLevel,
  input wire logic duplexLevel,
  output logic linkClk,
  output logic portSpeedIn,
  output logic portDuplexIn
);
  // ----------------------------------------------------------------
  // Link clock
  // ----------------------------------------------------------------
  // partner clock source
  // The clock stands low between frames, so no stray edge moves the pins.
  initial
  begin
    linkClk = 1'b0;
    #37;
    forever
    begin
      #HALF_NS;
      linkClk = clkRun ? ~linkClk : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status pins
  // ----------------------------------------------------------------
  // live pin levels
  // The pins are live, so they follow the bench with no framing at all.
  assign portSpeedIn = speedLevel;
  assign portDuplexIn = duplexLevel;
endmodule

/* testbench/test_switch_port0_mii_rmii_signal_adapter.sv */
// Purpose: Self-checking bench for the port 0 signal adapter in all four modes.
// Assumes: Zero wait state register slave; straps are set while reset is low.
// Notes: Each mode needs a fresh reset, since the mode only changes there.
`timescale 1ns/1ps
module test_switch_port0_mii_rmii_signal_adapter;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] modeStrap = 2'h0;
  logic speedPolStrap = 1'b0;
  logic duplexPolStrap = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic clkRun = 1'b0;
  logic speedLevel = 1'b1;
  logic duplexLevel = 1'b1;
  logic linkClk, portSpeedIn, portDuplexIn, portOutClockIn, portRmiiRefClockIn;
  logic [31:0] hrdata;
  logic hreadyout, hresp, portOutDataValid, portOutDataValidOe, portOutError;
  logic portOutErrorOe, portOutClockOut, portOutClockOe;
  logic portRmiiRefClockOut, portRmiiRefClockOe, linkSpeed, linkFullDuplex;
  logic [3:0] portOutData, portOutDataOe;
  logic [31:0] rngState = 32'h69EF;
  int failures = 0;
  int nTests = 0;
  int cycleCount = 0;

  // The 50 ns clock.
  initial
  begin
    forever #25 clk = ~clk;
  end

  // A clock pin carries the device's drive when enabled, else the partner's.
  assign portOutClockIn = portOutClockOe ? portOutClockOut : linkClk;
  assign portRmiiRefClockIn = portRmiiRefClockOe ? portRmiiRefClockOut : linkClk;

  spa_port_adapter u_dut (
    .clk(clk), .rst_n(rst_n), .modeStrap(modeStrap), .speedPolStrap(speedPolStrap),
    .duplexPolStrap(duplexPolStrap), .portSpeedIn(portSpeedIn),
    .portDuplexIn(portDuplexIn), .portOutClockIn(portOutClockIn),
    .portRmiiRefClockIn(portRmiiRefClockIn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .portOutData(portOutData), .portOutDataOe(portOutDataOe),
    .portOutDataValid(portOutDataValid), .portOutDataValidOe(portOutDataValidOe),
    .portOutError(portOutError), .portOutErrorOe(portOutErrorOe),
    .portOutClockOut(portOutClockOut), .portOutClockOe(portOutClockOe),
    .portRmiiRefClockOut(portRmiiRefClockOut), .portRmiiRefClockOe(portRmiiRefClockOe),
    .linkSpeed(linkSpeed), .linkFullDuplex(linkFullDuplex)
  );

  spa_link_partner u_partner (
    .clkRun(clkRun), .speedLevel(speedLevel), .duplexLevel(duplexLevel),
    .linkClk(linkClk), .portSpeedIn(portSpeedIn), .portDuplexIn(portDuplexIn)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Xorshift keeps every run identical for the same start value.
  function automatic logic [31:0] nextRand();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction

  // RMII carries two data bits, MII all four.
  function automatic logic [31:0] expPins(input logic [1:0] m, input logic [31:0] w);
    return m[1] ? {30'h0, w[1:0]} : {28'h0, w[3:0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits for hready under a bound, since the master assumes no latency.
  task automatic waitReady();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
      failures++;
  endtask

  task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
    check("resp", {31'h0, hresp}, 32'h0);
  endtask

  // A device-made clock must flip between two falling edges of clk.
  task automatic checkToggle(input string what, input logic useRef, input logic exp);
    logic first;
    @(negedge clk);
    first = useRef ? portRmiiRefClockOut : portOutClockOut;
    @(negedge clk);
    if (exp)
      check(what, useRef ? portRmiiRefClockOut : portOutClockOut, !first);
    @(posedge clk);
  endtask

  task automatic doReset(input logic [1:0] m);
    logic [31:0] r;
    r = nextRand();
    rst_n <= 1'b0;
    modeStrap <= m;
    speedPolStrap <= r[0];
    duplexPolStrap <= r[1];
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic stop_test();
    $display("TB: %0d checks, %0d failures", nTests, failures);
    if (failures == 0 && nTests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A hang counts as a mismatch; the whole run needs under a thousand cycles.
  always @(posedge clk)
  begin
    cycleCount++;
    if (cycleCount == 5000)
    begin
      failures++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] rd, w, cs;
    logic [1:0] m;
    logic sp, dp;
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(i);
      doReset(m);
      busXfer(1'b0, spa_pkg::SPA_STATUS_ADDR, 32'h0, rd);
      check("mode", {28'h0, rd[7:4]}, {28'h0, 4'h1 << m});
      modeStrap <= ~m;
      busXfer(1'b1, spa_pkg::SPA_STATUS_ADDR, 32'hFFFF_FFFF, rd);
      busXfer(1'b0, spa_pkg::SPA_STATUS_ADDR, 32'h0, rd);
      check("mode kept", {28'h0, rd[7:4]}, {28'h0, 4'h1 << m});
      busXfer(1'b0, spa_pkg::SPA_BASIC_CTRL_ADDR, 32'h0, rd);
      check("basic reset", rd, {16'h0, spa_pkg::SPA_BASIC_RESET});
      busXfer(1'b0, spa_pkg::SPA_SPECIAL_CTRL_ADDR, 32'h0, rd);
      check("special reset", rd, {16'h0, spa_pkg::SPA_SPECIAL_RESET});
      busXfer(1'b0, 8'h10, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      check("clock oe", portOutClockOe, m == 2'h1);
      checkToggle("clock out", 1'b0, m == 2'h1);
      for (int k = 0; k < 2; k++)
      begin
        w = nextRand() & 32'h0000_030F;
        w[spa_pkg::SPA_VALID_BIT] = (k == 0);
        busXfer(1'b1, spa_pkg::SPA_DATA_ADDR, w, rd);
        clkRun <= 1'b1;
        repeat (40) @(posedge clk);
        clkRun <= 1'b0;
        check("data", {28'h0, portOutData} & expPins(m, 32'hF), expPins(m, w));
        check("valid", portOutDataValid, w[spa_pkg::SPA_VALID_BIT]);
        check("valid oe", portOutDataValidOe, 1'b1);
        check("error oe", portOutErrorOe, m == 2'h0);
        if (m == 2'h0)
          check("error", portOutError, w[spa_pkg::SPA_ERROR_BIT]);
      end
      w = nextRand();
      sp = w[0];
      dp = w[1];
      speedLevel <= sp;
      duplexLevel <= dp;
      repeat (8) @(posedge clk);
      if (m == 2'h2)
        check("speed live", linkSpeed, sp ^ speedPolStrap);
      if (!m[0])
        check("duplex live", linkFullDuplex, dp ^ duplexPolStrap);
      cs = w & ((32'h1 << spa_pkg::SPA_SPEED_LSB_BIT) | (32'h1 << spa_pkg::SPA_DUPLEX_BIT));
      cs[spa_pkg::SPA_AUTONEG_BIT] = m[0];
      busXfer(1'b1, spa_pkg::SPA_BASIC_CTRL_ADDR, cs, rd);
      speedLevel <= ~sp;
      duplexLevel <= ~dp;
      repeat (8) @(posedge clk);
      check("speed ctl", linkSpeed, cs[spa_pkg::SPA_SPEED_LSB_BIT]);
      check("duplex ctl", linkFullDuplex, cs[spa_pkg::SPA_DUPLEX_BIT]);
      busXfer(1'b1, spa_pkg::SPA_SPECIAL_CTRL_ADDR, 32'h1 << spa_pkg::SPA_CLKDIR_BIT, rd);
      repeat (4) @(posedge clk);
      check("ref oe", portRmiiRefClockOe, m[1]);
      checkToggle("ref out", 1'b1, m[1]);
      cs = cs | (32'h1 << spa_pkg::SPA_ISOLATE_BIT);
      busXfer(1'b1, spa_pkg::SPA_BASIC_CTRL_ADDR, cs, rd);
      busXfer(1'b0, spa_pkg::SPA_BASIC_CTRL_ADDR, 32'h0, rd);
      check("basic rw", rd, cs);
      repeat (4) @(posedge clk);
      if (m[0])
        check("isolate", {portOutDataOe, portOutDataValidOe, portOutClockOe,
          portRmiiRefClockOe}, 32'h0);
      $display("TB: mode %0d done", i);
    end
    stop_test();
  end
endmodule
